// >>> include/cmt_defs.svh
`ifndef CMT_DEFS_SVH
`define CMT_DEFS_SVH
`define CMT_PIX_W          8
`define CMT_PIX_MAX        8'hff
`define CMT_COEF_W         16
`define CMT_FRAC           8
`define CMT_NCOEF          12
`define CMT_NCOEF_IDX      4'hc
`define CMT_OFS_BASE       9
`define CMT_IDX_W          4
`define CMT_PRESET_W       3
`define CMT_PRESET_CUSTOM  3'h7
`define CMT_PRESET_RST     3'h0
`define CMT_PRESET_BASE    16'h0080
`define CMT_RED_TBL        64'h80_98_90_88_80_70_68_80
`define CMT_BLUE_TBL       64'h80_68_70_78_88_98_a0_80
`define CMT_CC_ON_RST      1'b1
`define CMT_IDENTITY       192'h0000_0000_0000_0100_0000_0000_0000_0100_0000_0000_0000_0100
`define CMT_YUV_SET        192'h0080_0080_0000_ffeb_ff95_0080_0080_ffab_ffd5_001d_0096_004d
`define CMT_BOOST_SHIFT    6
`define CMT_GAMMA_KNEE     8'h80
`define CMT_GAMMA_OFS      8'h80
`define CMT_BUF_FULL       2'h2
`endif

// >>> include/cmt_pkg.sv
`include "cmt_defs.svh"
package cmt_pkg;
  typedef struct packed {
    logic                  sof;
    logic [`CMT_PIX_W-1:0] c2;
    logic [`CMT_PIX_W-1:0] c1;
    logic [`CMT_PIX_W-1:0] c0;
  } pixel_s;
  typedef logic [`CMT_NCOEF-1:0][`CMT_COEF_W-1:0] coef_set_t;
  typedef enum logic [1:0] {
    SEL_CC = 2'b01,
    SEL_LC = 2'b10
  } stage_sel_e;
endpackage

// >>> core/matrix_mac.sv
`timescale 1ns/1ps
`include "cmt_defs.svh"
module matrix_mac (
  // clock and control
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  input  wire logic               adv_i,
  input  wire logic               apply_i,
  input  wire cmt_pkg::coef_set_t coef_i,
  // pixel in
  input  wire logic               valid_i,
  input  wire cmt_pkg::pixel_s    pix_i,
  // pixel out
  output logic                    valid_o,
  output cmt_pkg::pixel_s         pix_o
);
  import cmt_pkg::*;
  logic                     valid_q, valid_d;
  pixel_s                   pix_q, pix_d;
  logic signed [26:0]       acc;
  logic [2:0][`CMT_PIX_W-1:0] chans, res;

  always_comb begin
    acc     = '0;
    chans   = {pix_i.c2, pix_i.c1, pix_i.c0};
    res     = chans;
    valid_d = valid_q;
    pix_d   = pix_q;
    if (adv_i) begin
      for (int r = 0; r < 3; r++) begin
        acc = '0;
        for (int k = 0; k < 3; k++) begin
          acc = acc + 27'($signed(coef_i[r*3+k]) * $signed({1'b0, chans[k]}));
        end
        acc = (acc >>> `CMT_FRAC) + 27'($signed(coef_i[`CMT_OFS_BASE+r]));
        // clamp rather than wrap: a wrapped channel shows as a coloured speck
        if (acc < 0) begin
          acc = '0;
        end else if (acc > 27'(`CMT_PIX_MAX)) begin
          acc = 27'(`CMT_PIX_MAX);
        end
        if (apply_i) begin
          res[r] = acc[`CMT_PIX_W-1:0];
        end
      end
      valid_d = valid_i;
      pix_d   = '{sof: pix_i.sof, c2: res[2], c1: res[1], c0: res[0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      valid_q <= 1'b0;
      pix_q   <= '0;
    end else begin
      valid_q <= valid_d;
      pix_q   <= pix_d;
    end
  end

  assign valid_o = valid_q;
  assign pix_o   = pix_q;
endmodule

// >>> core/color_matrix_transform.sv
`timescale 1ns/1ps
`include "cmt_defs.svh"
// How it works
// - each output channel is a 3x3 gain matrix times RGB plus an offset.
// - two matrix units exist: colour correction RGB->RGB and luma/chroma RGB->YUV.
// - with colour correction selected, writing transform_on 0 bypasses it, 1 applies it.
// - illuminant_preset picks one stored calibrated coefficient set for colour correction.
// - user coefficients apply only under the custom preset; written via index and value.
// - the luma/chroma unit sits after colour correction and after gamma.
// - the luma/chroma unit works only with a YUV output layout; no other enable.
// - coefficient_value reads back the gain or offset in use at coefficient_index.
// - saturation boost applies only while chroma_boost_on is 1; higher level, more vivid.
// - writes, preset ratio loads and the transform_on and coefficient_value read-backs work only while image_pipe_on is high.
// - coefficient_index spans nine gains row by column, then three offsets.
// - transform_on is read-only for the luma/chroma unit and shows the layout choice.
// - a new preset also loads red and blue white ratios; later writes overwrite them.
module color_matrix_transform (
  // clock, reset, enable
  input  wire logic                      clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      ce_i,
  // configuration
  input  wire logic                      image_pipe_on_i,
  input  wire cmt_pkg::stage_sel_e       transform_select_i,
  input  wire logic                      transform_on_wr_i,
  input  wire logic                      transform_on_i,
  output logic                           transform_on_o,
  input  wire logic [`CMT_IDX_W-1:0]     coefficient_index_i,
  input  wire logic                      coefficient_wr_i,
  input  wire logic [`CMT_COEF_W-1:0]    coefficient_value_i,
  output logic [`CMT_COEF_W-1:0]         coefficient_value_o,
  input  wire logic [`CMT_PRESET_W-1:0]  illuminant_preset_i,
  input  wire logic                      yuv_layout_i,
  input  wire logic                      gamma_on_i,
  input  wire logic                      chroma_boost_on_i,
  input  wire logic [7:0]                chroma_boost_level_i,
  // white balance ratios
  input  wire logic                      wb_wr_i,
  input  wire logic [7:0]                wb_red_i,
  input  wire logic [7:0]                wb_blue_i,
  output logic [7:0]                     red_white_ratio_o,
  output logic [7:0]                     blue_white_ratio_o,
  // pixel in
  input  wire logic                      s_valid_i,
  output logic                           s_ready_o,
  input  wire cmt_pkg::pixel_s           s_pix_i,
  // pixel out
  output logic                           m_valid_o,
  input  wire logic                      m_ready_i,
  output cmt_pkg::pixel_s                m_pix_o
);
  import cmt_pkg::*;
  localparam logic [63:0] RED_TBL  = `CMT_RED_TBL;
  localparam logic [63:0] BLUE_TBL = `CMT_BLUE_TBL;
  localparam coef_set_t   LC_SET   = `CMT_YUV_SET;

  function automatic coef_set_t preset_set(input logic [`CMT_PRESET_W-1:0] p);
    coef_set_t s;
    s    = `CMT_IDENTITY;
    s[0] = `CMT_PRESET_BASE + {8'h00, RED_TBL[{p, 3'b000} +: 8]};
    s[8] = `CMT_PRESET_BASE + {8'h00, BLUE_TBL[{p, 3'b000} +: 8]};
    return s;
  endfunction

  function automatic logic [7:0] boost(input logic [7:0] c, input logic [9:0] y, input logic [7:0] lvl);
    logic signed [10:0] diff;
    logic signed [19:0] prod;
    logic signed [19:0] sum;
    diff = $signed({3'b000, c}) - $signed({1'b0, y});
    prod = diff * $signed({1'b0, lvl});
    sum  = $signed({10'h000, y}) + (prod >>> `CMT_BOOST_SHIFT);
    if (sum < 0) begin
      return 8'h00;
    end else if (sum > 20'sd255) begin
      return `CMT_PIX_MAX;
    end
    return sum[7:0];
  endfunction

  function automatic logic [7:0] gamma_curve(input logic [7:0] x);
    if (x < `CMT_GAMMA_KNEE) begin
      return x + {1'b0, x[7:1]};
    end
    return {1'b0, x[7:1]} + `CMT_GAMMA_OFS;
  endfunction

  logic        adv, frame_load, cfg_ok, cc_use_on;
  coef_set_t   cc_src, cc_use;
  logic [7:0]  red_sel;
  logic        cc_on_q, cc_on_d, cc_on_act_q, cc_on_act_d, ton_rd_q, ton_rd_d;
  coef_set_t   user_q, user_d, cc_act_q, cc_act_d;
  logic [7:0]  red_q, red_d, blue_q, blue_d;
  logic [`CMT_PRESET_W-1:0] preset_prev_q, preset_prev_d;
  logic [`CMT_COEF_W-1:0]   coef_rd_q, coef_rd_d;
  logic        v1_q, v2_q, v2_d, v3_q, v3_d, v4_q;
  pixel_s      p1_q, p2_q, p2_d, p3_q, p3_d, p4_q;
  logic [9:0]  ysum;
  logic [1:0]  cnt_q, cnt_d;
  logic        wp_q, wp_d, rp_q, rp_d, push, pop;
  pixel_s      mem_q [2];
  pixel_s      mem_d [2];

  // pipe only moves while the buffer has room, so no in-flight word is lost
  assign adv        = ce_i && (cnt_q != `CMT_BUF_FULL);
  assign s_ready_o  = adv;
  assign frame_load = adv && s_valid_i && s_pix_i.sof;
  assign cfg_ok     = ce_i && image_pipe_on_i;
  assign cc_src     = (illuminant_preset_i == `CMT_PRESET_CUSTOM) ? user_q : preset_set(illuminant_preset_i);
  // the frame's first pixel already sees the new set
  assign cc_use     = frame_load ? cc_src : cc_act_q;
  assign cc_use_on  = frame_load ? cc_on_q : cc_on_act_q;
  assign red_sel    = RED_TBL[{illuminant_preset_i, 3'b000} +: 8];

  always_comb begin
    cc_on_d       = cc_on_q;
    user_d        = user_q;
    red_d         = red_q;
    blue_d        = blue_q;
    preset_prev_d = preset_prev_q;
    cc_act_d      = cc_act_q;
    cc_on_act_d   = cc_on_act_q;
    coef_rd_d     = coef_rd_q;
    ton_rd_d      = ton_rd_q;
    if (cfg_ok) begin
      if (transform_on_wr_i && transform_select_i == SEL_CC) begin
        cc_on_d = transform_on_i;
      end
      if (coefficient_wr_i && transform_select_i == SEL_CC && coefficient_index_i < `CMT_NCOEF_IDX) begin
        user_d[coefficient_index_i] = coefficient_value_i;
      end
      if (illuminant_preset_i != preset_prev_q) begin
        red_d  = red_sel;
        blue_d = BLUE_TBL[{illuminant_preset_i, 3'b000} +: 8];
      end
      if (wb_wr_i) begin
        red_d  = wb_red_i;
        blue_d = wb_blue_i;
      end
      preset_prev_d = illuminant_preset_i;
    end
    if (frame_load) begin
      cc_act_d    = cc_src;
      cc_on_act_d = cc_on_q;
    end
    if (ce_i) begin
      coef_rd_d = '0;
      ton_rd_d  = 1'b0;
      if (image_pipe_on_i) begin
        ton_rd_d = (transform_select_i == SEL_LC) ? yuv_layout_i : cc_on_q;
        if (coefficient_index_i < `CMT_NCOEF_IDX) begin
          coef_rd_d = (transform_select_i == SEL_LC) ? LC_SET[coefficient_index_i]
                                                      : cc_act_q[coefficient_index_i];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cc_on_q       <= `CMT_CC_ON_RST;
      cc_on_act_q   <= `CMT_CC_ON_RST;
      user_q        <= `CMT_IDENTITY;
      cc_act_q      <= preset_set(`CMT_PRESET_RST);
      red_q         <= RED_TBL[7:0];
      blue_q        <= BLUE_TBL[7:0];
      preset_prev_q <= `CMT_PRESET_RST;
      coef_rd_q     <= '0;
      ton_rd_q      <= 1'b0;
    end else begin
      cc_on_q       <= cc_on_d;
      cc_on_act_q   <= cc_on_act_d;
      user_q        <= user_d;
      cc_act_q      <= cc_act_d;
      red_q         <= red_d;
      blue_q        <= blue_d;
      preset_prev_q <= preset_prev_d;
      coef_rd_q     <= coef_rd_d;
      ton_rd_q      <= ton_rd_d;
    end
  end

  assign coefficient_value_o = coef_rd_q;
  assign transform_on_o      = ton_rd_q;
  assign red_white_ratio_o   = red_q;
  assign blue_white_ratio_o  = blue_q;

  // order: colour correction, boost, gamma, luma/chroma
  matrix_mac u_cc (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .adv_i   (adv),
    .apply_i (cc_use_on),
    .coef_i  (cc_use),
    .valid_i (s_valid_i),
    .pix_i   (s_pix_i),
    .valid_o (v1_q),
    .pix_o   (p1_q)
  );

  always_comb begin
    ysum = {2'b00, p1_q.c0} + {1'b0, p1_q.c1, 1'b0} + {2'b00, p1_q.c2};
    v2_d = v2_q;
    p2_d = p2_q;
    v3_d = v3_q;
    p3_d = p3_q;
    if (adv) begin
      v2_d = v1_q;
      p2_d = p1_q;
      if (chroma_boost_on_i) begin
        p2_d.c0 = boost(p1_q.c0, {2'b00, ysum[9:2]}, chroma_boost_level_i);
        p2_d.c1 = boost(p1_q.c1, {2'b00, ysum[9:2]}, chroma_boost_level_i);
        p2_d.c2 = boost(p1_q.c2, {2'b00, ysum[9:2]}, chroma_boost_level_i);
      end
      v3_d = v2_q;
      p3_d = p2_q;
      if (gamma_on_i) begin
        p3_d.c0 = gamma_curve(p2_q.c0);
        p3_d.c1 = gamma_curve(p2_q.c1);
        p3_d.c2 = gamma_curve(p2_q.c2);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      v2_q <= 1'b0;
      p2_q <= '0;
      v3_q <= 1'b0;
      p3_q <= '0;
    end else begin
      v2_q <= v2_d;
      p2_q <= p2_d;
      v3_q <= v3_d;
      p3_q <= p3_d;
    end
  end

  matrix_mac u_lc (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .adv_i   (adv),
    .apply_i (yuv_layout_i),
    .coef_i  (LC_SET),
    .valid_i (v3_q),
    .pix_i   (p3_q),
    .valid_o (v4_q),
    .pix_o   (p4_q)
  );

  // two-entry output buffer
  assign push = adv && v4_q;
  assign pop  = ce_i && m_ready_i && (cnt_q != 2'h0);

  always_comb begin
    cnt_d = cnt_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    mem_d = mem_q;
    if (push) begin
      mem_d[wp_q] = p4_q;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q    <= 2'h0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      cnt_q <= cnt_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      mem_q <= mem_d;
    end
  end

  assign m_valid_o = (cnt_q != 2'h0);
  assign m_pix_o   = mem_q[rp_q];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence accept_s;
    adv && s_valid_i;
  endsequence
  sequence drain_s;
    adv [*4];
  endsequence

  fixed_latency_a: assert property (accept_s ##1 drain_s |=> m_valid_o)
    else $error("accepted pixel did not reach output after five advances");
  cc_bypass_a: assert property ((adv && s_valid_i && !cc_use_on) |=> (p1_q == $past(s_pix_i)))
    else $error("colour correction not bypassed while off");
  lc_bypass_a: assert property ((adv && v3_q && !yuv_layout_i) |=> (p4_q == $past(p3_q)))
    else $error("luma chroma unit active without yuv layout");
  boost_off_a: assert property ((adv && !chroma_boost_on_i) |=> (p2_q == $past(p1_q)))
    else $error("saturation changed pixel while boost off");
  locked_read_a: assert property ((ce_i && !image_pipe_on_i) |=> (coefficient_value_o == '0 && !transform_on_o))
    else $error("settings readable while image pipe off");
  yuv_ro_a: assert property ((transform_on_wr_i && transform_select_i == SEL_LC) |=> $stable(cc_on_q))
    else $error("write to read-only yuv enable changed state");
  frame_hold_a: assert property (!frame_load |=> $stable(cc_act_q))
    else $error("active matrix changed mid frame");
  preset_ratio_a: assert property ((cfg_ok && illuminant_preset_i != preset_prev_q && !wb_wr_i)
                                   |=> (red_white_ratio_o == $past(red_sel)))
    else $error("preset change did not load red ratio");
  full_stall_a: assert property ((cnt_q == `CMT_BUF_FULL) |-> !s_ready_o)
    else $error("input accepted while buffer full");
endmodule

// >>> tb/pixel_sink.sv
`timescale 1ns/1ps
module pixel_sink (
  // clock
  input  wire logic            clk_i,
  // stream from the block
  input  wire logic            m_valid_i,
  input  wire cmt_pkg::pixel_s m_pix_i,
  output logic                 m_ready_o,
  // stall control
  input  wire logic            stall_i,
  input  wire logic            slow_i
);
  import cmt_pkg::*;
  pixel_s got[$];
  logic   tog = 1'b0;
  initial m_ready_o = 1'b1;
  // ready moves only off the sampling edge; slow mode halves the rate
  always @(negedge clk_i) begin
    tog       <= ~tog;
    m_ready_o <= ~stall_i & (~slow_i | tog);
  end
  // a word counts as taken only where ready was high at the edge
  always @(posedge clk_i) begin
    if (m_valid_i === 1'b1 && m_ready_o === 1'b1) begin
      got.push_back(m_pix_i);
    end
  end
endmodule

// >>> tb/color_matrix_transform_tb.sv
`timescale 1ns/1ps
module color_matrix_transform_tb;
  import cmt_pkg::*;
  logic       clk = 1'b0, srst = 1'b1, ce = 1'b1, pipe = 1'b1, on_wr = 1'b0, on_val = 1'b0, cwr = 1'b0;
  logic       yuv = 1'b0, gam = 1'b0, bst = 1'b0, wbw = 1'b0, s_valid = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [3:0] idx = 4'h0;
  logic [15:0] cval = 16'h0000;
  logic [2:0] preset = 3'h0;
  logic [7:0] lvl = 8'h40, wbr = 8'h00, wbb = 8'h00;
  stage_sel_e sel = SEL_CC;
  pixel_s     s_pix = '0;
  logic       on_o, s_ready, m_valid, m_ready, refused;
  logic [15:0] cv_o;
  logic [7:0] rr_o, br_o;
  pixel_s     m_pix;
  int         err_total = 0, checked = 0;
  logic [7:0] red_t [8] = '{8'h80, 8'h68, 8'h70, 8'h80, 8'h88, 8'h90, 8'h98, 8'h80};
  logic [7:0] blue_t [8] = '{8'h80, 8'ha0, 8'h98, 8'h88, 8'h78, 8'h70, 8'h68, 8'h80};
  logic [15:0] cm [12] = '{16'h0000, 16'h0200, 16'h0000, 16'h0100, 16'h0000, 16'h0000,
                           16'h0000, 16'h0000, 16'h0100, 16'hfffb, 16'h000a, 16'h0000};

  color_matrix_transform dut_u (
    .clk_i(clk), .srst_i(srst), .ce_i(ce), .image_pipe_on_i(pipe), .transform_select_i(sel),
    .transform_on_wr_i(on_wr), .transform_on_i(on_val), .transform_on_o(on_o),
    .coefficient_index_i(idx), .coefficient_wr_i(cwr), .coefficient_value_i(cval),
    .coefficient_value_o(cv_o), .illuminant_preset_i(preset), .yuv_layout_i(yuv), .gamma_on_i(gam),
    .chroma_boost_on_i(bst), .chroma_boost_level_i(lvl), .wb_wr_i(wbw), .wb_red_i(wbr),
    .wb_blue_i(wbb), .red_white_ratio_o(rr_o), .blue_white_ratio_o(br_o), .s_valid_i(s_valid),
    .s_ready_o(s_ready), .s_pix_i(s_pix), .m_valid_o(m_valid), .m_ready_i(m_ready), .m_pix_o(m_pix));
  pixel_sink sink_u (.clk_i(clk), .m_valid_i(m_valid), .m_pix_i(m_pix), .m_ready_o(m_ready),
    .stall_i(stall), .slow_i(slow));

  always #12.5 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic pixel_s px(input logic f, input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
    return '{f, b, g, r};
  endfunction
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  // holds the pixel until the edge that takes it
  task automatic send(input pixel_s p);
    int n;
    n = 0;
    @(negedge clk);
    s_valid = 1'b1;
    s_pix = p;
    #1;
    while (s_ready !== 1'b1 && n < 60) begin
      refused = 1'b1;
      @(negedge clk);
      #1;
      n++;
    end
    check("s_ready", s_ready, 1);
    @(posedge clk);
  endtask
  task automatic idle();
    @(negedge clk);
    s_valid = 1'b0;
  endtask
  task automatic want_pix(input string what, input pixel_s e);
    int n;
    n = 0;
    while (sink_u.got.size() == 0 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (sink_u.got.size() == 0) check(what, 32'hffffffff, e);
    else check(what, sink_u.got.pop_front(), e);
  endtask
  task automatic wcoef(input logic [3:0] i, input logic [15:0] v);
    @(negedge clk);
    idx = i;
    cval = v;
    cwr = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
  endtask
  task automatic rcoef(input logic [3:0] i, input logic [15:0] e);
    @(negedge clk);
    idx = i;
    settle();
    check("coefficient_value", cv_o, e);
  endtask
  task automatic won(input logic v);
    @(negedge clk);
    on_val = v;
    on_wr = 1'b1;
    @(negedge clk);
    on_wr = 1'b0;
  endtask

  task automatic t_latency();
    int n;
    n = 0;
    send(px(1'b1, 8'h0a, 8'h14, 8'h1e));
    @(negedge clk);
    s_valid = 1'b0;
    while (m_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("latency", n, 4);
    want_pix("bypass_pix", px(1'b1, 8'h0a, 8'h14, 8'h1e));
    $display("test latency done");
  endtask
  task automatic t_stall();
    @(negedge clk);
    ce = 1'b0;
    stall = 1'b1;
    #1;
    check("ce_low_ready", s_ready, 0);
    @(negedge clk);
    ce = 1'b1;
    refused = 1'b0;
    fork
      begin
        repeat (30) @(negedge clk);
        stall = 1'b0;
        slow = 1'b1;
      end
    join_none
    for (int i = 0; i < 10; i++) send(px(i == 0, 8'(i), 8'(i + 1), 8'(i + 2)));
    idle();
    check("refused_seen", refused, 1);
    for (int i = 0; i < 10; i++) want_pix("stall_order", px(i == 0, 8'(i), 8'(i + 1), 8'(i + 2)));
    slow = 1'b0;
    $display("test stall done");
  endtask
  task automatic t_custom();
    preset = 3'h7;
    for (int i = 0; i < 12; i++) wcoef(4'(i), cm[i]);
    wcoef(4'hc, 16'h1234);
    rcoef(4'h1, 16'h0000);
    send(px(1'b1, 8'd100, 8'd150, 8'd7));
    send(px(1'b0, 8'd3, 8'd4, 8'd5));
    idle();
    want_pix("custom_clamp", px(1'b1, 8'hff, 8'd110, 8'd7));
    want_pix("custom_ofs", px(1'b0, 8'd3, 8'd13, 8'd5));
    rcoef(4'h1, 16'h0200);
    rcoef(4'h9, 16'hfffb);
    rcoef(4'hc, 16'h0000);
    $display("test custom done");
  endtask
  task automatic t_enable();
    won(1'b0);
    settle();
    check("cc_on_read", on_o, 0);
    send(px(1'b0, 8'd3, 8'd4, 8'd5));
    send(px(1'b1, 8'd3, 8'd4, 8'd5));
    idle();
    want_pix("mid_frame_old", px(1'b0, 8'd3, 8'd13, 8'd5));
    want_pix("cc_bypass", px(1'b1, 8'd3, 8'd4, 8'd5));
    sel = SEL_LC;
    won(1'b1);
    yuv = 1'b1;
    settle();
    check("lc_on_read", on_o, 1);
    yuv = 1'b0;
    settle();
    check("lc_off_read", on_o, 0);
    sel = SEL_CC;
    settle();
    check("lc_write_refused", on_o, 0);
    won(1'b1);
    $display("test enable done");
  endtask
  task automatic t_yuv();
    preset = 3'h0;
    yuv = 1'b1;
    sel = SEL_LC;
    rcoef(4'h0, 16'h004d);
    rcoef(4'h3, 16'hffd5);
    rcoef(4'ha, 16'h0080);
    send(px(1'b1, 8'd100, 8'd100, 8'd100));
    idle();
    want_pix("yuv_grey", px(1'b1, 8'd100, 8'd128, 8'd128));
    // gamma is a level; flip it only once the first pixel has left the pipe
    @(negedge clk);
    gam = 1'b1;
    send(px(1'b0, 8'd100, 8'd100, 8'd100));
    idle();
    want_pix("gamma_then_yuv", px(1'b0, 8'd150, 8'd128, 8'd128));
    gam = 1'b0;
    yuv = 1'b0;
    sel = SEL_CC;
    $display("test yuv done");
  endtask
  task automatic t_boost();
    bst = 1'b1;
    lvl = 8'h00;
    send(px(1'b1, 8'd200, 8'd100, 8'd0));
    idle();
    want_pix("boost_grey", px(1'b1, 8'd100, 8'd100, 8'd100));
    lvl = 8'h80;
    send(px(1'b1, 8'd200, 8'd100, 8'd0));
    idle();
    want_pix("boost_vivid", px(1'b1, 8'hff, 8'd100, 8'd0));
    bst = 1'b0;
    lvl = 8'h00;
    send(px(1'b1, 8'd200, 8'd100, 8'd0));
    idle();
    want_pix("boost_off", px(1'b1, 8'd200, 8'd100, 8'd0));
    $display("test boost done");
  endtask
  task automatic t_pipe_off();
    @(negedge clk);
    pipe = 1'b0;
    wbr = 8'h33;
    wbw = 1'b1;
    @(negedge clk);
    wbw = 1'b0;
    settle();
    check("off_coef", cv_o, 0);
    check("off_on", on_o, 0);
    check("off_wb", rr_o, 8'h80);
    pipe = 1'b1;
    $display("test pipe_off done");
  endtask
  task automatic t_presets();
    for (int p = 1; p < 7; p++) begin
      preset = 3'(p);
      send(px(1'b1, 8'd1, 8'd1, 8'd1));
      idle();
      rcoef(4'h0, 16'h0080 + {8'h00, red_t[p]});
      rcoef(4'h8, 16'h0080 + {8'h00, blue_t[p]});
      check("red_ratio", rr_o, red_t[p]);
      check("blue_ratio", br_o, blue_t[p]);
      sink_u.got.delete();
    end
    wbr = 8'h11;
    wbb = 8'h22;
    wbw = 1'b1;
    @(negedge clk);
    wbw = 1'b0;
    settle();
    check("wb_over_red", rr_o, 8'h11);
    check("wb_over_blue", br_o, 8'h22);
    $display("test presets done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // bound well above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("Error watchdog expired");
    give_verdict();
  end
  initial begin
    repeat (20) @(negedge clk);
    check("rst_valid", m_valid, 0);
    check("rst_on", on_o, 0);
    check("rst_ratio", {rr_o, br_o}, 16'h8080);
    srst = 1'b0;
    $display("test reset done");
    t_latency();
    t_stall();
    t_custom();
    t_enable();
    t_yuv();
    t_boost();
    t_pipe_off();
    t_presets();
    give_verdict();
  end
endmodule
